// [acr_pkg.sv]
// package: register map, field layout and reset values for the channel six bank
package acr_pkg;

  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] CHANNEL_SIX_CONFIG_OFS      = 8'h27;
  localparam logic [7:0] CHANNEL_SIX_OFFSET_HIGH_OFS = 8'h28;
  localparam logic [7:0] CHANNEL_SIX_OFFSET_LOW_OFS  = 8'h29;
  localparam logic [7:0] CHANNEL_SIX_GAIN_HIGH_OFS   = 8'h2A;
  localparam logic [7:0] CHANNEL_SIX_GAIN_LOW_OFS    = 8'h2B;
  localparam logic [7:0] CHANNEL_SEVEN_CONFIG_OFS    = 8'h2C;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned PHASE_LSB    = 6;
  localparam int unsigned PHASE_W      = 10;
  localparam int unsigned DC_OFF_BIT   = 2;
  localparam int unsigned SEL_LSB      = 0;
  localparam int unsigned SEL_W        = 2;
  localparam int unsigned LOW_FLD_LSB  = 8;
  localparam int unsigned LOW_FLD_W    = 8;
  localparam int unsigned CAL_W        = 24;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] CONFIG_RST      = 16'h0000;
  localparam logic [15:0] OFFSET_HIGH_RST = 16'h0000;
  localparam logic [15:0] OFFSET_LOW_RST  = 16'h0000;
  localparam logic [15:0] GAIN_HIGH_RST   = 16'h8000;
  localparam logic [15:0] GAIN_LOW_RST    = 16'h0000;
  localparam logic [15:0] UNMAPPED_RDATA  = 16'h0000;

  // ----------------------------------------
  // input selector codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    ACR_SEL_PINS     = 2'h0,
    ACR_SEL_SHORTED  = 2'h1,
    ACR_SEL_TEST_POS = 2'h2,
    ACR_SEL_TEST_NEG = 2'h3
  } acr_input_sel_t;

endpackage : acr_pkg

// [acr_wr_if.sv]
// interface: decoded write strobes and write data toward the field store
`timescale 1ns/1ns
interface acr_wr_if;
  logic        cfg_we;
  logic        ofs_hi_we;
  logic        ofs_lo_we;
  logic        gain_hi_we;
  logic        gain_lo_we;
  logic [15:0] wdata;

  modport dec (output cfg_we, ofs_hi_we, ofs_lo_we, gain_hi_we, gain_lo_we, wdata);
  modport store (input cfg_we, ofs_hi_we, ofs_lo_we, gain_hi_we, gain_lo_we, wdata);
endinterface : acr_wr_if

// [acr_field.sv]
// one writable register field with its own reset value
`timescale 1ns/1ns
module acr_field
  #(parameter int unsigned W = 8,
    parameter logic [W-1:0] RST = '0)
  (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_b_i,
  // write port
  input  wire logic         we_i,
  input  wire logic [W-1:0] wdata_i,
  // stored value
  output logic      [W-1:0] val_o
  );

  logic [W-1:0] val_q;
  logic [W-1:0] val_d;

  always_comb begin
    val_d = val_q;
    if (we_i) begin
      val_d = wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      val_q <= RST;
    end else begin
      val_q <= val_d;
    end
  end

  assign val_o = val_q;

endmodule : acr_field

// [acr_regs.sv]
// channel six configuration and calibration register bank
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
module acr_regs
  import acr_pkg::*;
  (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_b_i,
  // register port
  input  wire logic [ADDR_W-1:0]    addr_i,
  input  wire logic [DATA_W-1:0]    wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [DATA_W-1:0]    rdata_o,
  // global dc filter control from the device
  input  wire logic                 global_dc_filter_setting_i,
  // channel controls toward the converter
  output logic      [PHASE_W-1:0]   chan_phase_delay_o,
  output logic                      chan_dc_filter_off_o,
  output logic                      chan_dc_filter_en_o,
  output logic      [SEL_W-1:0]     chan_input_select_o,
  output logic                      chan_use_pins_o,
  output logic      [CAL_W-1:0]     offset_cal_o,
  output logic      [CAL_W-1:0]     gain_cal_o
  );

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  acr_wr_if wr_bus ();

  logic hit_cfg;
  logic hit_ofs_hi;
  logic hit_ofs_lo;
  logic hit_gain_hi;
  logic hit_gain_lo;

  always_comb begin
    hit_cfg     = 1'b0;
    hit_ofs_hi  = 1'b0;
    hit_ofs_lo  = 1'b0;
    hit_gain_hi = 1'b0;
    hit_gain_lo = 1'b0;
    if (addr_i == CHANNEL_SIX_CONFIG_OFS) begin
      hit_cfg = 1'b1;
    end else if (addr_i == CHANNEL_SIX_OFFSET_HIGH_OFS) begin
      hit_ofs_hi = 1'b1;
    end else if (addr_i == CHANNEL_SIX_OFFSET_LOW_OFS) begin
      hit_ofs_lo = 1'b1;
    end else if (addr_i == CHANNEL_SIX_GAIN_HIGH_OFS) begin
      hit_gain_hi = 1'b1;
    end else if (addr_i == CHANNEL_SIX_GAIN_LOW_OFS) begin
      hit_gain_lo = 1'b1;
    end
  end

  // 2Ch and beyond fall through: the next channel owns them
  assign wr_bus.cfg_we     = wr_i && hit_cfg;
  assign wr_bus.ofs_hi_we  = wr_i && hit_ofs_hi;
  assign wr_bus.ofs_lo_we  = wr_i && hit_ofs_lo;
  assign wr_bus.gain_hi_we = wr_i && hit_gain_hi;
  assign wr_bus.gain_lo_we = wr_i && hit_gain_lo;
  assign wr_bus.wdata      = wdata_i;

  // ----------------------------------------
  // field storage
  // ----------------------------------------
  // only writable bits get flops, so reserved bits can never hold a value
  logic [PHASE_W-1:0]   phase_val;
  logic                 dc_off_val;
  logic [SEL_W-1:0]     sel_val;
  logic [DATA_W-1:0]    ofs_hi_val;
  logic [LOW_FLD_W-1:0] ofs_lo_val;
  logic [DATA_W-1:0]    gain_hi_val;
  logic [LOW_FLD_W-1:0] gain_lo_val;

  acr_field #(
    .W   (PHASE_W),
    .RST (CONFIG_RST[PHASE_LSB +: PHASE_W])
  ) u_phase (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .we_i       (wr_bus.cfg_we),
    .wdata_i    (wr_bus.wdata[PHASE_LSB +: PHASE_W]),
    .val_o      (phase_val)
  );

  acr_field #(
    .W   (1),
    .RST (CONFIG_RST[DC_OFF_BIT])
  ) u_dc_off (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .we_i       (wr_bus.cfg_we),
    .wdata_i    (wr_bus.wdata[DC_OFF_BIT]),
    .val_o      (dc_off_val)
  );

  acr_field #(
    .W   (SEL_W),
    .RST (CONFIG_RST[SEL_LSB +: SEL_W])
  ) u_sel (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .we_i       (wr_bus.cfg_we),
    .wdata_i    (wr_bus.wdata[SEL_LSB +: SEL_W]),
    .val_o      (sel_val)
  );

  acr_field #(
    .W   (DATA_W),
    .RST (OFFSET_HIGH_RST)
  ) u_ofs_hi (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .we_i       (wr_bus.ofs_hi_we),
    .wdata_i    (wr_bus.wdata),
    .val_o      (ofs_hi_val)
  );

  acr_field #(
    .W   (LOW_FLD_W),
    .RST (OFFSET_LOW_RST[LOW_FLD_LSB +: LOW_FLD_W])
  ) u_ofs_lo (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .we_i       (wr_bus.ofs_lo_we),
    .wdata_i    (wr_bus.wdata[LOW_FLD_LSB +: LOW_FLD_W]),
    .val_o      (ofs_lo_val)
  );

  acr_field #(
    .W   (DATA_W),
    .RST (GAIN_HIGH_RST)
  ) u_gain_hi (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .we_i       (wr_bus.gain_hi_we),
    .wdata_i    (wr_bus.wdata),
    .val_o      (gain_hi_val)
  );

  acr_field #(
    .W   (LOW_FLD_W),
    .RST (GAIN_LOW_RST[LOW_FLD_LSB +: LOW_FLD_W])
  ) u_gain_lo (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .we_i       (wr_bus.gain_lo_we),
    .wdata_i    (wr_bus.wdata[LOW_FLD_LSB +: LOW_FLD_W]),
    .val_o      (gain_lo_val)
  );
  // reset values come from the package into each field
  // reserved write bits are never routed to any field

  // ----------------------------------------
  // register images
  // ----------------------------------------
  logic [DATA_W-1:0] cfg_img;
  logic [DATA_W-1:0] ofs_lo_img;
  logic [DATA_W-1:0] gain_lo_img;

  always_comb begin
    cfg_img                           = '0;
    cfg_img[PHASE_LSB +: PHASE_W]     = phase_val;
    cfg_img[DC_OFF_BIT]               = dc_off_val;
    cfg_img[SEL_LSB +: SEL_W]         = sel_val;
    ofs_lo_img                        = '0;
    ofs_lo_img[LOW_FLD_LSB +: LOW_FLD_W]  = ofs_lo_val;
    gain_lo_img                       = '0;
    gain_lo_img[LOW_FLD_LSB +: LOW_FLD_W] = gain_lo_val;
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // data only valid in the cycle after the strobe; zero otherwise
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    if (rd_i) begin
      if (hit_cfg) begin
        rdata_d = cfg_img;
      end else if (hit_ofs_hi) begin
        rdata_d = ofs_hi_val;
      end else if (hit_ofs_lo) begin
        rdata_d = ofs_lo_img;
      end else if (hit_gain_hi) begin
        rdata_d = gain_hi_val;
      end else if (hit_gain_lo) begin
        rdata_d = gain_lo_img;
      end else begin
        rdata_d = UNMAPPED_RDATA;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  // ----------------------------------------
  // channel controls
  // ----------------------------------------
  acr_input_sel_t sel_enum;

  assign sel_enum             = acr_input_sel_t'(sel_val);
  assign chan_phase_delay_o   = phase_val;
  assign chan_dc_filter_off_o = dc_off_val;
  // the per-channel disable overrides the global enable, never the reverse
  assign chan_dc_filter_en_o  = global_dc_filter_setting_i && !dc_off_val;
  assign chan_input_select_o  = sel_val;
  assign chan_use_pins_o      = (sel_enum == ACR_SEL_PINS);
  assign offset_cal_o         = {ofs_hi_val, ofs_lo_val};
  assign gain_cal_o           = {gain_hi_val, gain_lo_val};

endmodule : acr_regs

// [acr_regs_props.sv]
// checker: port relations of the channel six register bank
`timescale 1ns/1ns
module acr_regs_props
  import acr_pkg::*;
  (
  // clock and reset
  input wire logic               core_clk_i,
  input wire logic               rst_b_i,
  // register port
  input wire logic [ADDR_W-1:0]  addr_i,
  input wire logic [DATA_W-1:0]  wdata_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire logic [DATA_W-1:0]  rdata_o,
  // channel controls
  input wire logic               global_dc_filter_setting_i,
  input wire logic [PHASE_W-1:0] chan_phase_delay_o,
  input wire logic               chan_dc_filter_off_o,
  input wire logic               chan_dc_filter_en_o,
  input wire logic [SEL_W-1:0]   chan_input_select_o,
  input wire logic               chan_use_pins_o,
  input wire logic [CAL_W-1:0]   offset_cal_o,
  input wire logic [CAL_W-1:0]   gain_cal_o
  );
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------
  // access steps
  // ----------------------------------------
  sequence s_rd(a); rd_i && addr_i == a; endsequence
  sequence s_wr(a); wr_i && addr_i == a; endsequence
  property p_rst_val;
    $rose(rst_b_i) |-> gain_cal_o == 24'h800000 && offset_cal_o == 24'h000000
      && chan_phase_delay_o == 10'h000 && chan_input_select_o == 2'h0
      && chan_dc_filter_off_o == 1'b0;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
  property p_cfg_rd;
    s_rd(8'h27) |=> rdata_o == {$past(chan_phase_delay_o), 3'h0,
      $past(chan_dc_filter_off_o), $past(chan_input_select_o)};
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
  property p_low_rsv;
    rd_i && (addr_i == 8'h29 || addr_i == 8'h2B) |=> rdata_o[7:0] == 8'h00;
  endproperty
  a_low_rsv: assert property (p_low_rsv) else $error("low reserved bits set");
  property p_unmapped;
    s_rd(8'h2C) |=> rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("next channel decoded");
  // read data stand for one cycle only and the bus idles at zero otherwise
  property p_rd_idle;
    !rd_i |=> rdata_o == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_cfg_wr;
    s_wr(8'h27) |=> chan_phase_delay_o == $past(wdata_i[15:6])
      && chan_dc_filter_off_o == $past(wdata_i[2]) && chan_input_select_o == $past(wdata_i[1:0]);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config write lost");
  property p_ofs_hi;
    s_wr(8'h28) |=> offset_cal_o[23:8] == $past(wdata_i) && $stable(offset_cal_o[7:0]);
  endproperty
  a_ofs_hi: assert property (p_ofs_hi) else $error("offset high write wrong");
  property p_gain_lo;
    s_wr(8'h2B) |=> gain_cal_o[7:0] == $past(wdata_i[15:8]) && $stable(gain_cal_o[23:8]);
  endproperty
  a_gain_lo: assert property (p_gain_lo) else $error("gain low write wrong");
  property p_dc_en;
    chan_dc_filter_en_o == (global_dc_filter_setting_i && !chan_dc_filter_off_o);
  endproperty
  a_dc_en: assert property (p_dc_en) else $error("dc filter enable wrong");
  property p_pins;
    chan_use_pins_o == (chan_input_select_o == 2'h0);
  endproperty
  a_pins: assert property (p_pins) else $error("pin select decode wrong");
endmodule : acr_regs_props

bind acr_regs acr_regs_props u_props (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .global_dc_filter_setting_i(global_dc_filter_setting_i),
  .chan_phase_delay_o(chan_phase_delay_o), .chan_dc_filter_off_o(chan_dc_filter_off_o),
  .chan_dc_filter_en_o(chan_dc_filter_en_o), .chan_input_select_o(chan_input_select_o),
  .chan_use_pins_o(chan_use_pins_o), .offset_cal_o(offset_cal_o), .gain_cal_o(gain_cal_o));

// [acr_regs_tb.sv]
// testbench: register access and field decode of the channel six bank
`timescale 1ns/1ns
module acr_regs_tb;
  import acr_pkg::*;
  logic               clk = 1'b0;
  logic               rst_b = 1'b0;
  logic [ADDR_W-1:0]  addr = 8'h00;
  logic [DATA_W-1:0]  wdata = 16'h0000;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic               glob = 1'b0;
  logic [DATA_W-1:0]  rdata;
  logic [PHASE_W-1:0] phase;
  logic               dc_off;
  logic               dc_en;
  logic [SEL_W-1:0]   sel;
  logic               pins;
  logic [CAL_W-1:0]   ofs;
  logic [CAL_W-1:0]   gain;
  int                 fail_count = 0;
  int                 checked = 0;
  always #2 clk = ~clk;
  acr_regs uut (.core_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .global_dc_filter_setting_i(glob),
    .chan_phase_delay_o(phase), .chan_dc_filter_off_o(dc_off), .chan_dc_filter_en_o(dc_en),
    .chan_input_select_o(sel), .chan_use_pins_o(pins), .offset_cal_o(ofs), .gain_cal_o(gain));
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  // data stand only in the cycle after the strobe, so sample just after that edge
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd_reg
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(8'h27, 16'h0000);
    rd_reg(8'h28, 16'h0000);
    rd_reg(8'h29, 16'h0000);
    rd_reg(8'h2A, 16'h8000);
    rd_reg(8'h2B, 16'h0000);
    chk(gain, 24'h800000);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) wr_reg(8'h27 + 8'(i), 16'hFFFF);
    rd_reg(8'h27, 16'hFFC7);
    rd_reg(8'h28, 16'hFFFF);
    rd_reg(8'h29, 16'hFF00);
    rd_reg(8'h2A, 16'hFFFF);
    rd_reg(8'h2B, 16'hFF00);
    rd_reg(8'h2C, 16'h0000);
    chk(ofs, 24'hFFFFFF);
    $display("test all ones done");
    wr_reg(8'h28, 16'h1234);
    wr_reg(8'h29, 16'h56FF);
    wr_reg(8'h2A, 16'h9ABC);
    wr_reg(8'h2B, 16'hDE01);
    wr_reg(8'h2C, 16'h0000);
    wr_reg(8'h26, 16'h0000);
    chk(ofs, 24'h123456);
    chk(gain, 24'h9ABCDE);
    rd_reg(8'h28, 16'h1234);
    $display("test calibration words done");
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      glob <= s[0];
      wr_reg(8'h27, {10'h201, 3'h7, s[2], s[1:0]});
      chk(24'(phase), 24'h000201);
      chk(24'(sel), 24'(s[1:0]));
      chk(24'(pins), 24'(s[1:0] == 2'h0));
      chk(24'(dc_off), 24'(s[2]));
      chk(24'(dc_en), 24'(s[0] & ~s[2]));
      rd_reg(8'h27, {10'h201, 3'h0, s[2], s[1:0]});
    end
    $display("test selector and filter done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(gain, 24'h800000);
    chk(ofs, 24'h000000);
    chk(24'(dc_en), 24'(glob));
    rd_reg(8'h27, 16'h0000);
    $display("test mid-run reset done");
    final_report();
  end
endmodule : acr_regs_tb
